/* verilog/xbar_defines.vh */
// Purpose: Shared constants for the crossbar master port control block.
// Assumes: Register bits are numbered with bit 0 as the most significant.
// Notes: Offsets are control bus word addresses.
`ifndef XBAR_DEFINES_VH
`define XBAR_DEFINES_VH

`define NUM_REQ 5
`define DCR_AW 8

`define ADDR_INT_STATUS 8'h20
`define ADDR_ARB_CFG 8'h23
`define ADDR_MASTER_CFG 8'h54
`define ADDR_ERR_STATUS 8'h56
`define ADDR_ERR_ADDR 8'h57

`define MCFG_RESET 32'h8000009F
`define MCFG_WMASK 32'h800000BE
`define MCFG_FIXED1 32'h00000001
`define ARB_RESET 32'h00432010
`define ARB_WMASK 32'h00777777

`define MCFG_ERR_LOCK 0
`define MCFG_PRIO_EN 24
`define MCFG_ETERM 26
`define MCFG_LOCK 27
`define MCFG_READ_ADDR_PIPELINE_ENABLE 28
`define MCFG_WRITE_ADDR_PIPELINE_ENABLE 29
`define MCFG_WRITE_POSTING_ENABLE 30

`define ARB_IR_MSB 9
`define ARB_IR_LSB 11
`define ARB_DW_MSB 13
`define ARB_DW_LSB 15
`define ARB_DR_MSB 17
`define ARB_DR_LSB 19
`define ARB_S1_MSB 21
`define ARB_S1_LSB 23
`define ARB_S0_MSB 25
`define ARB_S0_LSB 27
`define ARB_SYNC 29
`define ARB_MODE_MSB 30
`define ARB_MODE_LSB 31

`define INT_CFG_ERR 17

`define MODE_LRU 2'b00
`define MODE_RR 2'b01
`define MODE_FIXED 2'b10

`endif

/* verilog/xbar_arbiter.v */
// Purpose: Picks one of the crossbar requesters for the master port.
// Assumes: Priority 4 is highest and 0 lowest.
// Notes: Ties go to the lowest requester index.
`timescale 1ns/1ps
`include "xbar_defines.vh"

module xbar_arbiter #(
   parameter NUM_REQ = `NUM_REQ
) (
   input wire clk,
   input wire resetn,
   input wire [NUM_REQ-1:0] req,
   input wire [3*NUM_REQ-1:0] prio,
   input wire [1:0] mode,
   input wire prio_en,
   input wire take,
   output reg [2:0] winner,
   output reg any
);

   reg [2:0] rank_ff [0:NUM_REQ-1];
   reg [2:0] last_ff;
   reg [3:0] score;
   reg [3:0] best;
   reg [NUM_REQ-1:0] others;
   integer i;
   integer tmp;

   // Settings are read live, so a change applies at the next decision.
   always @* begin
      best = 4'h0;
      winner = 3'h0;
      any = 1'b0;
      score = 4'h0;
      tmp = 0;
      others = req;
      others[last_ff] = 1'b0;
      for (i = 0; i < NUM_REQ; i = i + 1) begin
         tmp = NUM_REQ - 1 - i;
         if (mode == `MODE_LRU) begin
            score = {1'b1, rank_ff[i]};
         end else if (prio_en) begin
            score = {1'b1, prio[3*i +: 3]};
         end else begin
            score = {1'b1, tmp[2:0]};
         end
         if (mode == `MODE_RR && last_ff == i && (|others)) begin
            score[3] = 1'b0;
         end
         if (req[i] && (!any || score > best)) begin
            best = score;
            winner = i[2:0];
            any = 1'b1;
         end
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_ff <= 3'h0;
      end else if (take) begin
         last_ff <= winner;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_REQ; g = g + 1) begin : g_rank
         localparam [2:0] INIT = g;
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               rank_ff[g] <= INIT;
            end else if (take) begin
               if (winner == g) begin
                  rank_ff[g] <= 3'h0;
               end else if (rank_ff[g] < rank_ff[winner]) begin
                  rank_ff[g] <= rank_ff[g] + 3'h1;
               end
            end
         end
      end
   endgenerate

endmodule // xbar_arbiter

/* verilog/crossbar_master_cfg_arbiter.v */
// Purpose: Master port configuration, arbitration and write sequencing.
// Assumes: Control bus requests are held until acknowledged.
// Notes: Requesters: 0 instr read, 1 data write, 2 data read, 3 slave
// port 1, 4 slave port 0.
// Contract
// - Write burst flag drops on final beat.
// - Drive 128-bit write data during writes.
// - Error lock keeps first recorded error.
// - Bit 24 enables arbitration priority.
// - Bit 27 permits locked transfers.
// - Bits 28, 29 enable address pipelining.
// - Write pipelining forced off without posting.
// - No posting means early ack, singles only.
// - Non-single without posting sets config error.
// - Priority four highest, zero lowest.
// - Priorities ignored in least-recently-used mode.
// - Five priority fields with fixed defaults.
// - Bit 29 enables the sync attribute.
// - Mode field selects LRU, round robin, fixed.
// - Master configuration at address 0x54.
// - Arbitration configuration at 0x23, tie-off defaults.
// - Sync blocks port until slave busy clears.
`timescale 1ns/1ps
`include "xbar_defines.vh"

module crossbar_master_cfg_arbiter #(
   parameter NUM_REQ = `NUM_REQ,
   parameter [0:31] MCFG_TIEOFF = `MCFG_RESET,
   parameter [0:31] ARB_TIEOFF = `ARB_RESET
) (
   input wire clk,
   input wire resetn,
   input wire dcr_read,
   input wire dcr_write,
   input wire [0:`DCR_AW-1] dcr_addr,
   input wire [0:31] dcr_wdata,
   output reg dcr_ack,
   output reg [0:31] dcr_rdata,
   input wire [NUM_REQ-1:0] rq_valid,
   input wire [NUM_REQ-1:0] rq_rnw,
   input wire [NUM_REQ-1:0] rq_burst,
   input wire [NUM_REQ-1:0] rq_lock,
   input wire [NUM_REQ-1:0] rq_sync,
   input wire [4*NUM_REQ-1:0] rq_blen,
   output reg [NUM_REQ-1:0] rq_grant,
   input wire [0:127] wr_data_in,
   output wire wdata_take,
   output reg master_request,
   output reg master_rnw,
   output reg master_lock_out,
   output reg [0:3] master_blen_out,
   output wire master_write_burst_out,
   output reg [0:127] master_write_data_out,
   input wire slave_addr_ack,
   input wire slave_wr_dack,
   input wire slave_rd_comp,
   input wire slave_busy,
   output wire [NUM_REQ-1:0] sync_busy_out,
   output wire read_pipe_en,
   output wire write_pipe_en,
   output wire early_data_ack,
   output wire cfg_err_flag,
   input wire err_event,
   input wire [0:31] err_status_in,
   input wire [0:31] err_addr_in
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_WDATA = 3'h2;
   localparam [2:0] S_RDATA = 3'h3;
   localparam [2:0] S_SYNC = 3'h4;
   // Reset value with write pipelining cleared whenever posting is off.
   localparam [0:31] MCFG_INIT = MCFG_TIEOFF[`MCFG_WRITE_POSTING_ENABLE] ? MCFG_TIEOFF :
      (MCFG_TIEOFF & ~(32'h80000000 >> `MCFG_WRITE_ADDR_PIPELINE_ENABLE));

   reg [0:31] mcfg_ff;
   reg [0:31] arb_ff;
   reg [0:31] int_ff;
   reg [0:31] err_status_ff;
   reg [0:31] err_addr_ff;
   reg [0:31] nxt_mcfg;
   reg [0:31] nxt_int;
   reg [0:31] nxt_err_status;
   reg [0:31] nxt_rdata;
   reg busy_ff;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [2:0] owner_ff;
   reg burst_ff;
   reg sync_ff;
   reg [3:0] beats_left_ff;
   reg cfg_err_set;
   reg take;
   wire [2:0] winner;
   wire any_req;
   wire dcr_take;
   wire wr_take;
   wire last_beat;
   wire [3*NUM_REQ-1:0] prio_flat;
   wire [0:31] mcfg_view;

   // Register access.
   assign dcr_take = (dcr_read | dcr_write) & ~busy_ff;
   assign wr_take = dcr_take & dcr_write;

   // Reserved bits read as zero, except the bit that must read one.
   assign mcfg_view = (mcfg_ff & `MCFG_WMASK) | `MCFG_FIXED1;

   always @* begin
      nxt_mcfg = mcfg_ff;
      if (wr_take && dcr_addr == `ADDR_MASTER_CFG) begin
         nxt_mcfg = dcr_wdata & `MCFG_WMASK;
         if (!dcr_wdata[`MCFG_WRITE_POSTING_ENABLE]) begin
            nxt_mcfg[`MCFG_WRITE_ADDR_PIPELINE_ENABLE] = 1'b0;
         end
      end
   end

   always @* begin
      case (dcr_addr)
         `ADDR_MASTER_CFG: nxt_rdata = mcfg_view;
         `ADDR_ARB_CFG: nxt_rdata = arb_ff & `ARB_WMASK;
         `ADDR_INT_STATUS: nxt_rdata = int_ff;
         `ADDR_ERR_STATUS: nxt_rdata = err_status_ff;
         `ADDR_ERR_ADDR: nxt_rdata = err_addr_ff;
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   // Flags: a hardware set wins over a software clear in the same cycle.
   always @* begin
      nxt_int = int_ff;
      if (wr_take && dcr_addr == `ADDR_INT_STATUS) begin
         nxt_int = int_ff & ~dcr_wdata;
      end
      if (cfg_err_set) begin
         nxt_int[`INT_CFG_ERR] = 1'b1;
      end
      nxt_err_status = err_status_ff;
      if (wr_take && dcr_addr == `ADDR_ERR_STATUS) begin
         nxt_err_status = err_status_ff & ~dcr_wdata;
      end
      if (err_event && (!mcfg_ff[`MCFG_ERR_LOCK] ||
          err_status_ff == 32'h00000000)) begin
         nxt_err_status = err_status_in;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mcfg_ff <= MCFG_INIT;
         arb_ff <= ARB_TIEOFF;
         int_ff <= 32'h00000000;
         err_status_ff <= 32'h00000000;
         err_addr_ff <= 32'h00000000;
         busy_ff <= 1'b0;
         dcr_ack <= 1'b0;
         dcr_rdata <= 32'h00000000;
      end else begin
         mcfg_ff <= nxt_mcfg;
         int_ff <= nxt_int;
         err_status_ff <= nxt_err_status;
         if (err_event && (!mcfg_ff[`MCFG_ERR_LOCK] ||
             err_status_ff == 32'h00000000)) begin
            err_addr_ff <= err_addr_in;
         end
         if (wr_take && dcr_addr == `ADDR_ARB_CFG) begin
            arb_ff <= dcr_wdata & `ARB_WMASK;
         end
         if (dcr_take) begin
            busy_ff <= 1'b1;
         end else if (!dcr_read && !dcr_write) begin
            busy_ff <= 1'b0;
         end
         dcr_ack <= dcr_take;
         if (dcr_take && dcr_read) begin
            dcr_rdata <= nxt_rdata;
         end
      end
   end

   // Mode outputs.
   assign read_pipe_en = mcfg_ff[`MCFG_READ_ADDR_PIPELINE_ENABLE];
   assign write_pipe_en = mcfg_ff[`MCFG_WRITE_ADDR_PIPELINE_ENABLE];
   assign early_data_ack = ~mcfg_ff[`MCFG_WRITE_POSTING_ENABLE];
   assign cfg_err_flag = int_ff[`INT_CFG_ERR];

   // Arbitration.
   assign prio_flat = {arb_ff[`ARB_S0_MSB:`ARB_S0_LSB],
                       arb_ff[`ARB_S1_MSB:`ARB_S1_LSB],
                       arb_ff[`ARB_DR_MSB:`ARB_DR_LSB],
                       arb_ff[`ARB_DW_MSB:`ARB_DW_LSB],
                       arb_ff[`ARB_IR_MSB:`ARB_IR_LSB]};

   xbar_arbiter #(
      .NUM_REQ(NUM_REQ)
   ) u_arbiter (
      .clk(clk),
      .resetn(resetn),
      .req(rq_valid),
      .prio(prio_flat),
      .mode(arb_ff[`ARB_MODE_MSB:`ARB_MODE_LSB]),
      .prio_en(mcfg_ff[`MCFG_PRIO_EN]),
      .take(take),
      .winner(winner),
      .any(any_req)
   );

   // Transfer sequencing.
   assign last_beat = (beats_left_ff == 4'h0);
   assign master_write_burst_out = (state_ff == S_WDATA) & burst_ff &
                                   ~(last_beat & slave_wr_dack);
   assign wdata_take = ((state_ff == S_ADDR) & slave_addr_ack & ~master_rnw)
                     | ((state_ff == S_WDATA) & slave_wr_dack & ~last_beat);

   genvar g;
   generate
      for (g = 0; g < NUM_REQ; g = g + 1) begin : g_sync
         assign sync_busy_out[g] = (state_ff == S_SYNC) &
                                   (owner_ff == g) & slave_busy;
      end
   endgenerate

   // A decision is only made in idle, so a grant is never disturbed.
   always @* begin
      nxt_state = state_ff;
      take = 1'b0;
      cfg_err_set = 1'b0;
      case (state_ff)
         S_IDLE: begin
            if (any_req) begin
               take = 1'b1;
               if (!mcfg_ff[`MCFG_WRITE_POSTING_ENABLE] && rq_burst[winner]) begin
                  cfg_err_set = 1'b1;
               end else begin
                  nxt_state = S_ADDR;
               end
            end
         end
         S_ADDR: begin
            if (slave_addr_ack) begin
               nxt_state = master_rnw ? S_RDATA : S_WDATA;
            end
         end
         S_WDATA: begin
            if (slave_wr_dack && last_beat) begin
               nxt_state = sync_ff ? S_SYNC : S_IDLE;
            end
         end
         S_RDATA: begin
            if (slave_rd_comp) begin
               nxt_state = sync_ff ? S_SYNC : S_IDLE;
            end
         end
         S_SYNC: begin
            if (!slave_busy) begin
               nxt_state = S_IDLE;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= S_IDLE;
         owner_ff <= 3'h0;
         burst_ff <= 1'b0;
         sync_ff <= 1'b0;
         beats_left_ff <= 4'h0;
         rq_grant <= {NUM_REQ{1'b0}};
         master_request <= 1'b0;
         master_rnw <= 1'b0;
         master_lock_out <= 1'b0;
         master_blen_out <= 4'h0;
         master_write_data_out <= 128'h0;
      end else begin
         state_ff <= nxt_state;
         rq_grant <= {NUM_REQ{1'b0}};
         if (take) begin
            rq_grant[winner] <= 1'b1;
            owner_ff <= winner;
            burst_ff <= rq_burst[winner];
            beats_left_ff <= rq_burst[winner] ?
                             rq_blen[4*winner +: 4] : 4'h0;
            master_blen_out <= rq_burst[winner] ?
                               rq_blen[4*winner +: 4] : 4'h0;
            sync_ff <= arb_ff[`ARB_SYNC] & rq_sync[winner];
            master_rnw <= rq_rnw[winner];
            master_lock_out <= rq_lock[winner] &
                               mcfg_ff[`MCFG_LOCK];
         end
         if (take && !cfg_err_set) begin
            master_request <= 1'b1;
         end else if (slave_addr_ack) begin
            master_request <= 1'b0;
         end
         if (state_ff == S_WDATA && slave_wr_dack && !last_beat) begin
            beats_left_ff <= beats_left_ff - 4'h1;
         end
         if (wdata_take) begin
            master_write_data_out <= wr_data_in;
         end
         if (nxt_state == S_IDLE) begin
            master_lock_out <= 1'b0;
         end
      end
   end

endmodule // crossbar_master_cfg_arbiter

/* verification/crossbar_master_cfg_arbiter_checker.sv */
// Purpose: Port assertions for the crossbar master port block.
// Assumes: One clock; reset is asynchronous and active low.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module crossbar_master_cfg_arbiter_checker #(
   parameter NUM_REQ = 5
) (
   input wire clk,
   input wire resetn,
   input wire dcr_read,
   input wire dcr_write,
   input wire dcr_ack,
   input wire [NUM_REQ-1:0] rq_valid,
   input wire [NUM_REQ-1:0] rq_burst,
   input wire [NUM_REQ-1:0] rq_grant,
   input wire [0:127] wr_data_in,
   input wire wdata_take,
   input wire master_request,
   input wire master_write_burst_out,
   input wire [0:127] master_write_data_out,
   input wire slave_wr_dack,
   input wire slave_busy,
   input wire [NUM_REQ-1:0] sync_busy_out,
   input wire write_pipe_en,
   input wire early_data_ack,
   input wire cfg_err_flag
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   ack_once_a: assert property (
      dcr_ack |-> $past(dcr_read | dcr_write) ##1 !dcr_ack)
      else $error("bad control bus ack");
   pipe_forced_a: assert property (
      early_data_ack |-> !write_pipe_en)
      else $error("write pipelining without posting");
   single_only_a: assert property (
      early_data_ack |-> !master_write_burst_out)
      else $error("burst while posting is off");
   burst_drop_a: assert property (
      $fell(master_write_burst_out) |-> slave_wr_dack)
      else $error("burst flag dropped off the final beat");
   burst_hold_a: assert property (
      master_write_burst_out && !slave_wr_dack |=>
      master_write_burst_out || slave_wr_dack)
      else $error("burst flag dropped before a beat");
   wdata_load_a: assert property (
      wdata_take |=> master_write_data_out == $past(wr_data_in))
      else $error("write data not loaded");
   err_cause_a: assert property (
      $rose(cfg_err_flag) |-> $past(early_data_ack && |(rq_valid & rq_burst)))
      else $error("config error without cause");
   sync_fwd_a: assert property (
      |sync_busy_out |-> slave_busy)
      else $error("busy forwarded while slave idle");
   sync_block_a: assert property (
      |sync_busy_out |-> rq_grant == 0 && !master_request)
      else $error("transfer passed during sync hold");
   grant_valid_a: assert property (
      |rq_grant |-> $onehot(rq_grant) && |(rq_grant & $past(rq_valid)))
      else $error("grant to a requester not asking");
endmodule // crossbar_master_cfg_arbiter_checker

bind crossbar_master_cfg_arbiter crossbar_master_cfg_arbiter_checker
   #(.NUM_REQ(NUM_REQ)) chk (.clk, .resetn, .dcr_read, .dcr_write,
   .dcr_ack, .rq_valid, .rq_burst, .rq_grant, .wr_data_in, .wdata_take,
   .master_request, .master_write_burst_out, .master_write_data_out,
   .slave_wr_dack, .slave_busy, .sync_busy_out, .write_pipe_en,
   .early_data_ack, .cfg_err_flag);

/* verification/plb_slave_model.sv */
// Purpose: Behavioural slave on the far side of the master port.
// Assumes: One transfer is outstanding at a time.
// Notes: Slow mode adds gaps between steps and a busy tail.
`timescale 1ns/1ps
module plb_slave_model (
   input wire clk,
   input wire resetn,
   input wire master_request,
   input wire master_rnw,
   input wire [0:3] master_blen_out,
   input wire slow,
   output reg slave_addr_ack,
   output reg slave_wr_dack,
   output reg slave_rd_comp,
   output reg slave_busy
);
   reg act, rd, gap;
   reg [4:0] left;
   reg [2:0] tail;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {act, rd, gap, left, tail} <= 11'h000;
         {slave_addr_ack, slave_wr_dack, slave_rd_comp, slave_busy} <= 4'h0;
      end else begin
         slave_addr_ack <= 1'b0;
         slave_wr_dack <= 1'b0;
         slave_rd_comp <= 1'b0;
         gap <= 1'b0;
         if (tail != 3'h0)
            tail <= tail - 3'h1;
         slave_busy <= slow && (act || tail > 3'h1);
         if (!gap && !act && master_request) begin
            slave_addr_ack <= 1'b1;
            act <= 1'b1;
            rd <= master_rnw;
            left <= {1'b0, master_blen_out} + 5'h01;
            gap <= slow;
         end else if (!gap && act) begin
            slave_rd_comp <= rd;
            slave_wr_dack <= !rd;
            left <= left - 5'h01;
            gap <= slow;
            if (rd || left == 5'h01) begin
               act <= 1'b0;
               tail <= slow ? 3'h4 : 3'h0;
            end
         end
      end
   end
endmodule // plb_slave_model

/* verification/crossbar_master_cfg_arbiter_tb.sv */
// Purpose: Self-checking bench for the crossbar master port block.
// Assumes: The slave model answers every transfer sent out.
// Notes: Expected results wait in queues for the monitor.
`timescale 1ns/1ps
module crossbar_master_cfg_arbiter_tb;
   reg clk = 0, resetn = 0, dcr_read = 0, dcr_write = 0, slow = 0;
   reg err_event = 0, lk = 1;
   reg [0:7] dcr_addr = 0;
   reg [0:31] dcr_wdata = 0, err_status_in = 0, err_addr_in = 0;
   reg [0:31] v, e, ea, eb;
   reg [4:0] rq_valid = 0, rq_rnw = 0, rq_burst = 0, rq_lock = 0, rq_sync = 0;
   reg [19:0] rq_blen = 0;
   reg [0:127] wr_data_in = 0;
   wire dcr_ack, wdata_take, master_request, master_rnw, master_lock_out;
   wire master_write_burst_out, slave_addr_ack, slave_wr_dack, slave_rd_comp;
   wire slave_busy, read_pipe_en, write_pipe_en, early_data_ack, cfg_err_flag;
   wire [0:31] dcr_rdata;
   wire [4:0] rq_grant, sync_busy_out;
   wire [0:3] master_blen_out;
   wire [0:127] master_write_data_out;
   integer failures = 0, compares = 0, seed = 23, dacks = 0, bdacks = 0;
   integer syncs = 0, i;
   logic [31:0] rq[$], gq[$];
   crossbar_master_cfg_arbiter dut (.clk, .resetn, .dcr_read, .dcr_write,
      .dcr_addr, .dcr_wdata, .dcr_ack, .dcr_rdata, .rq_valid, .rq_rnw,
      .rq_burst, .rq_lock, .rq_sync, .rq_blen, .rq_grant, .wr_data_in,
      .wdata_take, .master_request, .master_rnw, .master_lock_out,
      .master_blen_out, .master_write_burst_out, .master_write_data_out,
      .slave_addr_ack, .slave_wr_dack, .slave_rd_comp, .slave_busy,
      .sync_busy_out, .read_pipe_en, .write_pipe_en, .early_data_ack,
      .cfg_err_flag, .err_event, .err_status_in, .err_addr_in);
   plb_slave_model slave (.clk, .resetn, .master_request, .master_rnw,
      .master_blen_out, .slow, .slave_addr_ack, .slave_wr_dack,
      .slave_rd_comp, .slave_busy);
   always #10 clk = ~clk;
   always @(negedge clk)
      wr_data_in <= {$random(seed), $random(seed), $random(seed),
         $random(seed)};
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task bus(input w, input [0:7] a, input [0:31] d, input [0:31] x);
      integer n;
      begin
         n = 0;
         @(negedge clk);
         if (!w)
            rq.push_back(x);
         dcr_write = w;
         dcr_read = !w;
         dcr_addr = a;
         dcr_wdata = d;
         @(posedge clk);
         while (!dcr_ack && n < 20) begin
            @(posedge clk);
            n = n + 1;
         end
         @(negedge clk);
         dcr_write = 0;
         dcr_read = 0;
      end
   endtask
   task xfer(input [4:0] r, s, input rw, input [3:0] len, input [4:0] g,
      input go);
      integer n;
      begin
         n = 0;
         @(negedge clk);
         gq.push_back(g);
         rq_valid = r;
         rq_sync = s;
         rq_rnw = {5{rw}};
         rq_burst = {5{len != 0}};
         rq_blen = {5{len}};
         while (!(|rq_grant) && n < 50) begin
            @(negedge clk);
            n = n + 1;
         end
         rq_valid = 0;
         while (go && !(slave_rd_comp || slave_wr_dack &&
            !master_write_burst_out) && n < 90) begin
            @(negedge clk);
            n = n + 1;
         end
         while (slave_busy && n < 99) begin
            @(negedge clk);
            n = n + 1;
         end
         if (n >= 90)
            failures = failures + 1;
         repeat (2) @(negedge clk);
      end
   endtask
   always @(posedge clk) begin
      if (dcr_ack && dcr_read)
         chk(dcr_rdata, rq.pop_front());
      if (|rq_grant)
         chk(rq_grant, gq.pop_front());
      if (slave_addr_ack)
         chk(master_lock_out, lk);
      if (slave_wr_dack)
         dacks = dacks + 1;
      if (slave_wr_dack && master_write_burst_out)
         bdacks = bdacks + 1;
      if (|sync_busy_out)
         syncs = syncs + 1;
   end
   initial begin
      #400000;
      failures = failures + 1;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      resetn = 1;
      rq_lock = 5'h1F;
      bus(0, 8'h54, 0, 32'h8000009F);
      bus(0, 8'h23, 0, 32'h00432010);
      bus(0, 8'h10, 0, 0);
      chk({read_pipe_en, write_pipe_en, early_data_ack}, 3'h6);
      xfer(5'h1F, 0, 1, 0, 5'h10, 1);
      bus(1, 8'h23, 32'h00012341, 0);
      xfer(5'h1F, 0, 1, 0, 5'h08, 1);
      bus(1, 8'h23, 32'h00012342, 0);
      xfer(5'h1F, 0, 1, 0, 5'h10, 1);
      bus(1, 8'h54, 32'h8000001F, 0);
      xfer(5'h1F, 0, 1, 0, 5'h01, 1);
      bus(1, 8'h54, 32'h8000008F, 0);
      lk = 0;
      xfer(5'h02, 0, 1, 0, 5'h02, 1);
      lk = 1;
      bus(1, 8'h54, 32'h8000009F, 0);
      xfer(5'h02, 0, 0, 4'h3, 5'h02, 1);
      chk(dacks, 4);
      chk(bdacks, 3);
      bus(1, 8'h23, 32'h00012346, 0);
      slow = 1;
      xfer(5'h04, 5'h04, 1, 0, 5'h04, 1);
      chk(syncs != 0, 1);
      xfer(5'h02, 0, 0, 4'h2, 5'h02, 1);
      chk(dacks, 7);
      chk(bdacks, 5);
      bus(1, 8'h23, 32'h00012342, 0);
      syncs = 0;
      xfer(5'h04, 5'h04, 1, 0, 5'h04, 1);
      chk(syncs, 0);
      slow = 0;
      v = $random(seed) & 32'hFFFFFFDF;
      e = (v & 32'h800000BE) | 32'h1;
      if (!e[30])
         e[29] = 0;
      bus(1, 8'h54, v, 0);
      bus(0, 8'h54, 0, e);
      bus(1, 8'h54, 32'h8000009D, 0);
      bus(0, 8'h54, 0, 32'h80000099);
      chk({write_pipe_en, early_data_ack}, 2'h1);
      xfer(5'h02, 0, 0, 4'h1, 5'h02, 0);
      chk(cfg_err_flag, 1);
      bus(0, 8'h20, 0, 32'h00004000);
      bus(1, 8'h20, 32'h00004000, 0);
      bus(0, 8'h20, 0, 0);
      bus(1, 8'h54, 32'h8000009F, 0);
      for (i = 0; i < 2; i = i + 1) begin
         @(negedge clk);
         err_event = 1;
         err_status_in = $random(seed) | 1;
         err_addr_in = $random(seed);
         if (i == 0)
            {ea, eb} = {err_status_in, err_addr_in};
         @(negedge clk);
         err_event = 0;
      end
      bus(0, 8'h56, 0, ea);
      bus(0, 8'h57, 0, eb);
      report_and_stop;
   end
endmodule // crossbar_master_cfg_arbiter_tb
